// ==== src/rlb_regs.svh ====
`ifndef RLB_REGS_SVH
`define RLB_REGS_SVH

// Register word offsets on the plain register port.
`define RLB_ADDR_MODE 4'h0
`define RLB_ADDR_BID 4'h1
`define RLB_ADDR_REPLY 4'h2
`define RLB_ADDR_IVAL 4'h3
`define RLB_ADDR_STATUS 4'h4

// Link role numbers held in the mode register.
`define RLB_MODE_MASTER 8'h0C
`define RLB_MODE_SLAVE 8'h0D
`define RLB_MODE_RST 8'h0C

// Bid address encoding.
`define RLB_MAX_DROP 8'h63
`define RLB_BID_BASE 8'h64
`define RLB_BID_MAX 8'hC7

// Reset values of the wait settings, in time-base ticks.
`define RLB_REPLY_RST 16'h07D0
`define RLB_IVAL_RST 16'h0064

// Time base: one tick per millisecond at a 4 ns clock.
`define RLB_TICK_NS 1000000
`define RLB_CLK_NS 4
`define RLB_TICK_CYC (`RLB_TICK_NS / `RLB_CLK_NS)

// Status register field positions.
`define RLB_ST_STATE_LSB 0
`define RLB_ST_SWEEP_BIT 3
`define RLB_ST_PEND_BIT 4
`define RLB_ST_COUNT_LSB 8

`endif

// ==== src/rlb_pkg.sv ====
package rlb_pkg;

    // Scheduler states; the slave role uses only ST_IDLE to ST_WAIT, ST_BIDW and ST_IVAL are the master's.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_KEY,
        ST_XMIT,
        ST_WAIT,
        ST_BIDW,
        ST_IVAL
    } rlb_state_t;

    // One link transmission request handed to the framing logic.
    typedef struct packed {
        logic is_bid;
        logic [6:0] drop;
        logic [7:0] tag;
    } rlb_tx_t;

endpackage

// ==== src/rlb_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module rlb_timer #(
    parameter int WIDTH = 16
) (
    input wire logic clk_in, // System clock.
    input wire logic nrst_in, // Asynchronous reset, active low.
    input wire logic tick_in, // Time-base tick, one cycle.
    input wire logic load_in, // Reload pulse.
    input wire logic [WIDTH-1:0] value_in, // Ticks to wait.
    output logic done_out // Count has reached zero.
);

    logic [WIDTH-1:0] count;

    // A load wins over a tick in the same cycle so a fresh wait is never
    // shortened by one tick.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            count <= '0;
        else if (load_in)
            count <= value_in;
        else if (tick_in && count != '0)
            count <= count - WIDTH'(1);
    end

    assign done_out = (count == '0) && !load_in;

endmodule

`default_nettype wire

// ==== src/rlb_sched.sv ====
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rlb_regs.svh"

module rlb_sched #(
    parameter int TICK_CYC = `RLB_TICK_CYC,
    parameter int DEPTH = 4
) (
    input wire logic clk_in, // System clock, 250 MHz.
    input wire logic nrst_in, // Asynchronous reset, active low.
    input wire logic [3:0] addr_in, // Register word address.
    input wire logic [15:0] wdata_in, // Register write data.
    input wire logic wr_in, // Register write strobe.
    input wire logic rd_in, // Register read strobe.
    output logic [15:0] rdata_out, // Read data, cycle after strobe.
    input wire logic loc_valid_in, // Local message offered.
    input wire logic [7:0] loc_tag_in, // Local message buffer tag.
    output logic loc_ready_out, // Message buffer has room.
    output logic rts_out, // Request to send to modem.
    input wire logic cts_in, // Clear to send from modem pin.
    output logic tx_start_out, // Start one link frame, pulse.
    output rlb_pkg::rlb_tx_t tx_out, // Frame request contents.
    input wire logic tx_end_in, // Frame fully sent, pulse.
    input wire logic link_done_in, // Transaction complete, pulse.
    input wire logic bid_rx_in // Slave: own bid received, pulse.
);

    localparam int AW = $clog2(DEPTH);

    rlb_pkg::rlb_state_t state;
    logic [7:0] mode;
    logic [7:0] bid_val;
    logic [7:0] sweep_top;
    logic bid_pend;
    logic sweep_on;
    logic [15:0] reply_set;
    logic [15:0] ival_set;
    logic cts_meta;
    logic cts_sync;
    logic [31:0] div_cnt;
    logic tick;
    logic reply_load;
    logic ival_load;
    logic reply_done;
    logic ival_done;
    logic [7:0] q_tag [DEPTH];
    logic [AW-1:0] q_rd;
    logic [AW-1:0] q_wr;
    logic [AW:0] q_cnt;
    logic q_push;
    logic q_pop;
    logic is_slave;
    logic next_bid;
    logic open_txn;
    logic sent_on_bid;

    // Bid values below one hundred name the drop; above, drop plus 100.
    function automatic logic [6:0] drop_of(input logic [7:0] v);
        logic [7:0] d;
        d = (v < `RLB_BID_BASE) ? v : v - `RLB_BID_BASE;
        return d[6:0];
    endfunction

    assign is_slave = (mode == `RLB_MODE_SLAVE);

    // The modem line comes from a pin, so it is resynchronised first.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cts_meta <= 1'b0;
            cts_sync <= 1'b0;
        end
        else
        begin
            cts_meta <= cts_in;
            cts_sync <= cts_meta;
        end
    end

    // Common time base for both wait counters.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            div_cnt <= '0;
            tick <= 1'b0;
        end
        else if (div_cnt == 32'(TICK_CYC - 1))
        begin
            div_cnt <= '0;
            tick <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + 32'h1;
            tick <= 1'b0;
        end
    end

    rlb_timer #(.WIDTH(16)) u_reply (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .tick_in(tick),
        .load_in(reply_load),
        .value_in(reply_set),
        .done_out(reply_done)
    );

    rlb_timer #(.WIDTH(16)) u_ival (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .tick_in(tick),
        .load_in(ival_load),
        .value_in(ival_set),
        .done_out(ival_done)
    );

    // Register writes; a bid write above 199 is outside the modes kept
    // here and is ignored so a stray value cannot bid a drop above 99.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            mode <= `RLB_MODE_RST;
            reply_set <= `RLB_REPLY_RST;
            ival_set <= `RLB_IVAL_RST;
        end
        else if (wr_in)
        begin
            if (addr_in == `RLB_ADDR_MODE)
                mode <= wdata_in[7:0];
            if (addr_in == `RLB_ADDR_REPLY)
                reply_set <= wdata_in;
            if (addr_in == `RLB_ADDR_IVAL)
                ival_set <= wdata_in;
        end
    end

    // Read data is registered and stands only in the cycle after the
    // strobe; unmapped words read as zero.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            rdata_out <= 16'h0000;
        else if (rd_in)
        begin
            unique case (addr_in)
                `RLB_ADDR_MODE: rdata_out <= {8'h00, mode};
                `RLB_ADDR_BID: rdata_out <= {8'h00, bid_val};
                `RLB_ADDR_REPLY: rdata_out <= reply_set;
                `RLB_ADDR_IVAL: rdata_out <= ival_set;
                `RLB_ADDR_STATUS:
                begin
                    rdata_out <= 16'h0000;
                    rdata_out[`RLB_ST_STATE_LSB +: 3] <= state;
                    rdata_out[`RLB_ST_SWEEP_BIT] <= sweep_on;
                    rdata_out[`RLB_ST_PEND_BIT] <= bid_pend;
                    rdata_out[`RLB_ST_COUNT_LSB +: 8] <= 8'(q_cnt);
                end
                default: rdata_out <= 16'h0000;
            endcase
        end
        else
            rdata_out <= 16'h0000;
    end

    // Message buffer: oldest first, so a slave releases in arrival order.
    assign loc_ready_out = (q_cnt != (AW+1)'(DEPTH));
    assign q_push = loc_valid_in && loc_ready_out;
    assign q_pop = tx_start_out && !tx_out.is_bid;

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            q_rd <= '0;
            q_wr <= '0;
            q_cnt <= '0;
        end
        else
        begin
            if (q_push)
                q_wr <= AW'((q_wr + 1'b1) % DEPTH);
            if (q_pop)
                q_rd <= AW'((q_rd + 1'b1) % DEPTH);
            if (q_push && !q_pop)
                q_cnt <= q_cnt + 1'b1;
            else if (q_pop && !q_push)
                q_cnt <= q_cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (q_push)
            q_tag[q_wr] <= loc_tag_in;
    end

    // The bid step that follows the interval: stop at 100, else count down.
    assign next_bid = sweep_on && bid_val != `RLB_BID_BASE;

    // Wait counters restart on entry to ST_BIDW, the slave reply window and an interval after ST_BIDW.
    assign reply_load = (!is_slave && state == rlb_pkg::ST_XMIT
                         && tx_end_in && tx_out.is_bid)
                        || (is_slave && state == rlb_pkg::ST_IDLE
                            && bid_rx_in);
    assign ival_load = state == rlb_pkg::ST_BIDW
                       && (reply_done || link_done_in) && sweep_on;

    // Link scheduler. Software bid writes are folded in here because the
    // sweep counter is also stepped by the scheduler; the write is applied
    // last so that a new bid is never lost to a same-cycle clear or step.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state <= rlb_pkg::ST_IDLE;
            bid_val <= 8'h00;
            sweep_top <= 8'h00;
            bid_pend <= 1'b0;
            sweep_on <= 1'b0;
            rts_out <= 1'b0;
            tx_start_out <= 1'b0;
            tx_out <= '0;
        end
        else
        begin
            tx_start_out <= 1'b0;
            unique case (state)
                rlb_pkg::ST_IDLE:
                begin
                    if (is_slave)
                    begin
                        // A bid that arrives in ST_IDLE is answered while a message waits.
                        if (bid_rx_in && q_cnt != '0)
                        begin
                            tx_out <= '{1'b0, 7'h00, q_tag[q_rd]};
                            rts_out <= 1'b1;
                            state <= rlb_pkg::ST_KEY;
                        end
                    end
                    else if (q_cnt != '0)
                    begin
                        tx_out <= '{1'b0, 7'h00, q_tag[q_rd]};
                        rts_out <= 1'b1;
                        state <= rlb_pkg::ST_KEY;
                    end
                    else if (bid_pend)
                    begin
                        tx_out <= '{1'b1, drop_of(bid_val), 8'h00};
                        bid_pend <= 1'b0;
                        rts_out <= 1'b1;
                        state <= rlb_pkg::ST_KEY;
                    end
                end
                rlb_pkg::ST_KEY:
                begin
                    if (is_slave && reply_done)
                    begin
                        rts_out <= 1'b0;
                        state <= rlb_pkg::ST_IDLE;
                    end
                    else if (cts_sync)
                    begin
                        tx_start_out <= 1'b1;
                        state <= rlb_pkg::ST_XMIT;
                    end
                end
                rlb_pkg::ST_XMIT:
                begin
                    if (tx_end_in)
                    begin
                        rts_out <= 1'b0;
                        state <= tx_out.is_bid ? rlb_pkg::ST_BIDW
                                               : rlb_pkg::ST_WAIT;
                    end
                end
                rlb_pkg::ST_WAIT:
                begin
                    if (link_done_in || (is_slave && reply_done))
                    begin
                        if (is_slave || !sweep_on)
                            state <= rlb_pkg::ST_IDLE;
                        else
                            state <= rlb_pkg::ST_IVAL;
                    end
                end
                rlb_pkg::ST_BIDW:
                begin
                    // A silent slave is closed out by the reply timeout.
                    if (reply_done || link_done_in)
                        state <= sweep_on ? rlb_pkg::ST_IVAL
                                          : rlb_pkg::ST_IDLE;
                end
                rlb_pkg::ST_IVAL:
                begin
                    if (q_cnt != '0)
                    begin
                        tx_out <= '{1'b0, 7'h00, q_tag[q_rd]};
                        rts_out <= 1'b1;
                        state <= rlb_pkg::ST_KEY;
                    end
                    else if (ival_done && next_bid)
                    begin
                        bid_val <= bid_val - 8'h01;
                        tx_out <= '{1'b1, drop_of(bid_val - 8'h01), 8'h00};
                        rts_out <= 1'b1;
                        state <= rlb_pkg::ST_KEY;
                    end
                    else if (ival_done)
                    begin
                        sweep_on <= 1'b0;
                        state <= rlb_pkg::ST_IDLE;
                    end
                end
                default: state <= rlb_pkg::ST_IDLE;
            endcase
            // Exactly one hundred is a single bid to drop zero, not a sweep.
            if (wr_in && addr_in == `RLB_ADDR_BID
                && wdata_in[7:0] <= `RLB_BID_MAX && wdata_in[15:8] == 8'h00)
            begin
                bid_val <= wdata_in[7:0];
                sweep_top <= wdata_in[7:0];
                bid_pend <= 1'b1;
                sweep_on <= (wdata_in[7:0] > `RLB_BID_BASE);
            end
        end
    end

    // Helper state for the checks below.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            open_txn <= 1'b0;
            sent_on_bid <= 1'b0;
        end
        else
        begin
            if (tx_start_out)
                open_txn <= 1'b1;
            else if (state == rlb_pkg::ST_IDLE || state == rlb_pkg::ST_IVAL)
                open_txn <= 1'b0;
            if (is_slave && bid_rx_in && state == rlb_pkg::ST_IDLE)
                sent_on_bid <= 1'b0;
            else if (tx_start_out)
                sent_on_bid <= 1'b1;
        end
    end

    a_start_keyed: assert property (@(posedge clk_in) disable iff (!nrst_in)
        tx_start_out |-> rts_out && $past(cts_sync))
        else $error("Frame started without clear to send.");

    a_single_flight: assert property (@(posedge clk_in) disable iff (!nrst_in)
        tx_start_out |-> !$past(open_txn))
        else $error("Second frame started with one open.");

    a_drop_range: assert property (@(posedge clk_in) disable iff (!nrst_in)
        tx_start_out && tx_out.is_bid |-> tx_out.drop <= 7'h63)
        else $error("Bid drop above 99.");

    a_slave_no_bid: assert property (@(posedge clk_in) disable iff (!nrst_in)
        tx_start_out && is_slave |-> !tx_out.is_bid && sent_on_bid == 1'b0
        ##0 $past(state, 1) != rlb_pkg::ST_IDLE)
        else $error("Slave sent without a bid or twice on one bid.");

    a_slave_window: assert property (@(posedge clk_in) disable iff (!nrst_in)
        is_slave && state == rlb_pkg::ST_KEY && reply_done
        |=> state == rlb_pkg::ST_IDLE && !rts_out)
        else $error("Slave kept keying past reply window.");

    a_bid_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_in && addr_in == `RLB_ADDR_BID && wdata_in == 16'h0064
        && state == rlb_pkg::ST_IDLE && q_cnt == '0
        |=> ##1 tx_out.is_bid && tx_out.drop == 7'h00)
        else $error("Bid value 100 did not target drop zero.");

    a_sweep_start: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_in && addr_in == `RLB_ADDR_BID && wdata_in > 16'h0064
        && wdata_in <= 16'h00C7 |=> sweep_on && bid_val == sweep_top)
        else $error("Sweep not started from written value.");

    a_step_order: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $rose(state == rlb_pkg::ST_IVAL) && $past(state) == rlb_pkg::ST_BIDW
        |-> $past(reply_done || link_done_in))
        else $error("Interval entered before reply wait ended.");

    a_silent_end: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state == rlb_pkg::ST_BIDW && reply_done
        |=> state != rlb_pkg::ST_BIDW)
        else $error("Bid wait outlived reply timeout.");

    a_slave_release: assert property (@(posedge clk_in) disable iff (!nrst_in)
        is_slave && state == rlb_pkg::ST_WAIT && link_done_in
        |=> state == rlb_pkg::ST_IDLE && !rts_out)
        else $error("Slave kept the link after its transaction.");

endmodule

`default_nettype wire

// ==== verif/rlb_modem.sv ====
`timescale 1ns/1ps
`default_nettype none

// Modem plus the far end of the link: keys up, sends frames, replies.
module rlb_modem #(
    parameter int CTS_DLY = 3,
    parameter int FRAME = 6,
    parameter int TURN = 4
) (
    input wire logic clk_in, // System clock.
    input wire logic nrst_in, // Asynchronous reset, active low.
    input wire logic rts_in, // Request to send from the port.
    input wire logic tx_start_in, // Frame start pulse.
    input wire rlb_pkg::rlb_tx_t tx_in, // Frame contents.
    input wire logic silent_in, // Far slave has nothing for a bid.
    output logic cts_out, // Clear to send.
    output logic tx_end_out, // Frame sent pulse.
    output logic link_done_out // Transaction complete pulse.
);
    int key_cnt;
    int frm_cnt;
    int rep_cnt;

    // The carrier needs a few cycles to come up and drops with the request.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            key_cnt <= 0;
            cts_out <= 1'h0;
        end
        else if (!rts_in)
        begin
            key_cnt <= 0;
            cts_out <= 1'h0;
        end
        else if (key_cnt < CTS_DLY)
            key_cnt <= key_cnt + 1;
        else
            cts_out <= 1'h1;
    end

    // Frame time, then a reply unless the far slave stays quiet.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            frm_cnt <= 0;
            rep_cnt <= 0;
            tx_end_out <= 1'h0;
            link_done_out <= 1'h0;
        end
        else
        begin
            tx_end_out <= (frm_cnt == 1);
            link_done_out <= (rep_cnt == 1);
            if (tx_start_in)
                frm_cnt <= FRAME;
            else if (frm_cnt > 0)
                frm_cnt <= frm_cnt - 1;
            if (frm_cnt == 1 && !(tx_in.is_bid && silent_in))
                rep_cnt <= TURN;
            else if (rep_cnt > 0)
                rep_cnt <= rep_cnt - 1;
        end
    end
endmodule
`default_nettype wire

// ==== verif/rlb_sched_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module rlb_sched_test;
    typedef struct packed {
        logic [3:0] a;
        logic w;
        logic [15:0] d;
        logic [15:0] e;
    } rlb_row_t;
    logic clk_in, nrst_in, wr_in, rd_in, loc_valid_in, loc_ready_out;
    logic rts_out, cts_in, tx_start_out, tx_end_in, link_done_in;
    logic bid_rx_in, silent, open;
    logic [3:0] addr_in;
    logic [7:0] loc_tag_in;
    logic [15:0] wdata_in, rdata_out, rd_val;
    rlb_pkg::rlb_tx_t tx_out;
    logic [15:0] seen[$];
    int errors, total_checks;
    rlb_row_t rows[14] = '{'{4'h0, 1'h0, 16'h0000, 16'h000C},
        '{4'h2, 1'h0, 16'h0000, 16'h07D0}, '{4'h3, 1'h0, 16'h0000, 16'h0064},
        '{4'h4, 1'h0, 16'h0000, 16'h0000}, '{4'h5, 1'h0, 16'h0000, 16'h0000},
        '{4'h0, 1'h1, 16'h000D, 16'h0000}, '{4'h0, 1'h0, 16'h0000, 16'h000D},
        '{4'h0, 1'h1, 16'h000C, 16'h0000}, '{4'h2, 1'h1, 16'h0008, 16'h0000},
        '{4'h2, 1'h0, 16'h0000, 16'h0008}, '{4'h3, 1'h1, 16'h0004, 16'h0000},
        '{4'h3, 1'h0, 16'h0000, 16'h0004}, '{4'h7, 1'h1, 16'h1234, 16'h0000},
        '{4'h7, 1'h0, 16'h0000, 16'h0000}};
    logic [15:0] bids[3] = '{16'h0005, 16'h0063, 16'h0064};
    logic [6:0] drops[3] = '{7'h05, 7'h63, 7'h00};

    rlb_sched #(.TICK_CYC(4), .DEPTH(4)) DUT (.clk_in(clk_in),
        .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .loc_valid_in(loc_valid_in), .loc_tag_in(loc_tag_in),
        .loc_ready_out(loc_ready_out), .rts_out(rts_out), .cts_in(cts_in),
        .tx_start_out(tx_start_out), .tx_out(tx_out),
        .tx_end_in(tx_end_in), .link_done_in(link_done_in),
        .bid_rx_in(bid_rx_in));

    rlb_modem modem (.clk_in(clk_in), .nrst_in(nrst_in), .rts_in(rts_out),
        .tx_start_in(tx_start_out), .tx_in(tx_out), .silent_in(silent),
        .cts_out(cts_in), .tx_end_out(tx_end_in),
        .link_done_out(link_done_in));

    // Free-running 250 MHz clock.
    initial
    begin
        clk_in = 1'h0;
        forever #2 clk_in = ~clk_in;
    end

    task automatic close_out();
        $display("Checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg,
                got, exp);
        end
    endtask

    task automatic give_up(input string msg);
        errors++;
        $display("CHECK FAILED at %0t: %s timed out", $time, msg);
        close_out();
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'h1;
        @(posedge clk_in);
        wr_in <= 1'h0;
    endtask

    // Read data stands only in the cycle after the strobe.
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'h1;
        @(posedge clk_in);
        rd_in <= 1'h0;
        @(negedge clk_in);
        d = rdata_out;
    endtask

    task automatic push(input logic [7:0] tag);
        @(posedge clk_in);
        loc_valid_in <= 1'h1;
        loc_tag_in <= tag;
        @(posedge clk_in);
        loc_valid_in <= 1'h0;
    endtask

    // Drop field of a plain message is not defined, so it is masked off.
    task automatic tx_chk(input logic [15:0] exp, mask, input string msg);
        for (int i = 0; i < 400 && seen.size() == 0; i++)
            @(posedge clk_in);
        if (seen.size() == 0)
            give_up(msg);
        chk(seen.pop_front() & mask, exp, msg);
    endtask

    task automatic wait_idle();
        logic [15:0] s;
        s = 16'hFFFF;
        for (int i = 0; i < 300 && s !== 16'h0000; i++)
            reg_rd(4'h4, s);
        if (s !== 16'h0000)
            give_up("idle");
    endtask

    // Log frame starts; a second plain message may not overlap the first.
    always @(posedge clk_in)
    begin
        if (tx_start_out === 1'h1)
        begin
            seen.push_back(tx_out);
            chk({14'h0000, rts_out, cts_in}, 16'h0003, "keyed");
            chk({15'h0000, open}, 16'h0000, "overlap");
            open <= !tx_out.is_bid;
        end
        else if (link_done_in === 1'h1)
            open <= 1'h0;
    end

    initial
    begin
        {nrst_in, wr_in, rd_in, loc_valid_in, bid_rx_in, open} = 6'h00;
        {addr_in, loc_tag_in, wdata_in} = 28'h0000000;
        silent = 1'h0;
        errors = 0;
        total_checks = 0;
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'h1;
        // Register table rows: reset values, roles, unmapped place.
        foreach (rows[i])
        begin
            if (rows[i].w)
                reg_wr(rows[i].a, rows[i].d);
            else
            begin
                reg_rd(rows[i].a, rd_val);
                chk(rd_val, rows[i].e, "register");
            end
        end
        push(8'h11);
        push(8'h22);
        tx_chk(16'h0011, 16'h80FF, "first message");
        tx_chk(16'h0022, 16'h80FF, "queued message");
        wait_idle();
        foreach (bids[i])
        begin
            reg_wr(4'h1, bids[i]);
            tx_chk({1'h1, drops[i], 8'h00}, 16'hFFFF, "bid");
            wait_idle();
        end
        // A quiet slave leaves the master waiting out its reply window.
        silent = 1'h1;
        reg_wr(4'h1, 16'h0007);
        tx_chk(16'h8700, 16'hFFFF, "quiet bid");
        repeat (20) @(posedge clk_in);
        reg_rd(4'h4, rd_val);
        chk(rd_val & 16'h0007, 16'h0004, "bid wait");
        wait_idle();
        reg_wr(4'h1, 16'h0066);
        tx_chk(16'h8200, 16'hFFFF, "sweep start");
        push(8'h33);
        tx_chk(16'h0033, 16'h80FF, "in interval");
        tx_chk(16'h8100, 16'hFFFF, "sweep step");
        tx_chk(16'h8000, 16'hFFFF, "sweep end");
        wait_idle();
        reg_wr(4'h1, 16'h00C8);
        repeat (60) @(posedge clk_in);
        chk(16'(seen.size()), 16'h0000, "no stray bid");
        // Slave role: hold until bid, one oldest message per bid.
        reg_wr(4'h0, 16'h000D);
        for (int i = 0; i < 4; i++)
            push(8'hA0 + 8'(i));
        repeat (60) @(posedge clk_in);
        chk(16'(seen.size()), 16'h0000, "held");
        chk({15'h0000, loc_ready_out}, 16'h0000, "full");
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_in);
            bid_rx_in <= 1'h1;
            @(posedge clk_in);
            bid_rx_in <= 1'h0;
            repeat (60) @(posedge clk_in);
            chk(16'(seen.size()), 16'(i < 4), "one per bid");
            if (i < 4)
                tx_chk(16'h00A0 + 16'(i), 16'h80FF, "oldest");
        end
        wait_idle();
        // Reset in the middle of keying clears the link side.
        reg_wr(4'h0, 16'h000C);
        push(8'h44);
        for (int i = 0; i < 50 && rts_out !== 1'h1; i++)
            @(posedge clk_in);
        nrst_in <= 1'h0;
        @(negedge clk_in);
        chk({13'h0000, rts_out, tx_start_out, loc_ready_out}, 16'h0001,
            "reset outputs");
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'h1;
        open <= 1'h0;
        reg_rd(4'h2, rd_val);
        chk(rd_val, 16'h07D0, "reply reset");
        close_out();
    end
endmodule
`default_nettype wire
